// File: src/lcs_pkg.sv
/*
 Package for the common-row scan timing block: duty table, division
 constants and level encodings. Assumes a single 200 MHz clock domain.
*/
package lcs_pkg;
    localparam int unsigned CLOCK_MHZ = 200;
    localparam int unsigned ROWS = 20;
    localparam int unsigned DUTY_SEL_W = 3;
    localparam int unsigned ROW_CNT_W = 6;
    // Oscillator emulation: one oscillator tick every OSC_DIV clocks
    localparam int unsigned OSC_KHZ = 430;
    localparam int unsigned OSC_DIV = (CLOCK_MHZ * 1000) / OSC_KHZ;
    localparam int unsigned OSC_CNT_W = 10;
    // Oscillator ticks per row period
    localparam logic [7:0] ROW_TICKS = 8'h40;
    // Drive level codes on each common output
    localparam logic [1:0] LVL_SEL_A = 2'h0;
    localparam logic [1:0] LVL_SEL_B = 2'h1;
    localparam logic [1:0] LVL_NSEL_A = 2'h2;
    localparam logic [1:0] LVL_NSEL_B = 2'h3;
    // Select code to rows per frame; codes 4 to 7 all give 32 rows
    typedef logic [ROW_CNT_W-1:0] lcs_rows_t;
    localparam lcs_rows_t DUTY_TABLE [8] = '{
        6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h20, 6'h20, 6'h20
    };
endpackage

// File: src/lcs_sync.sv
/*
 Two-flop synchroniser for pin inputs.
 Assumes inputs are asynchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_sync (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_async,
    output logic o_sync
);
    logic stage1;
    logic stage2;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end
    assign o_sync = stage2;
endmodule // lcs_sync
`default_nettype wire

// File: src/lcs_timing_gen.sv
/*
 Timing generator: divides oscillator ticks into the column clocks,
 row shift strobe, AC phase and frame marker. Held idle when disabled.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_timing_gen
    import lcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_osc_tick,
    input wire logic [lcs_pkg::ROW_CNT_W-1:0] i_rows,
    output logic o_phase_1,
    output logic o_phase_2,
    output logic o_strobe,
    output logic o_ac_phase,
    output logic o_frame
);
    import lcs_pkg::*;
    logic [7:0] tick_cnt;
    logic [ROW_CNT_W-1:0] row_cnt;
    logic phase;
    logic next_phase;
    logic [7:0] next_tick_cnt;
    logic [ROW_CNT_W-1:0] next_row_cnt;
    logic next_strobe;
    logic next_ac;
    logic next_frame;

    always_comb begin
        next_phase = phase;
        next_tick_cnt = tick_cnt;
        next_row_cnt = row_cnt;
        next_strobe = o_strobe;
        next_ac = o_ac_phase;
        next_frame = o_frame;
        if (!i_enable) begin
            // Slave mode: generator frozen at idle
            next_phase = 1'b0;
            next_tick_cnt = 8'h00;
            next_row_cnt = '0;
            next_strobe = 1'b0;
            next_frame = 1'b0;
        end else if (i_osc_tick) begin
            next_phase = ~phase;
            next_tick_cnt = tick_cnt + 8'h01;
            // Strobe high for the first half of each row period
            next_strobe = (next_tick_cnt < (ROW_TICKS >> 1));
            if (next_tick_cnt == ROW_TICKS) begin
                next_tick_cnt = 8'h00;
                next_strobe = 1'b1;
                if (row_cnt + 6'h01 >= i_rows) begin
                    next_row_cnt = '0;
                    next_frame = 1'b1;
                    next_ac = ~o_ac_phase;
                end else begin
                    next_row_cnt = row_cnt + 6'h01;
                    next_frame = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= 1'b0;
            tick_cnt <= 8'h00;
            row_cnt <= '0;
            o_strobe <= 1'b0;
            o_ac_phase <= 1'b0;
            o_frame <= 1'b0;
        end else begin
            phase <= next_phase;
            tick_cnt <= next_tick_cnt;
            row_cnt <= next_row_cnt;
            o_strobe <= next_strobe;
            o_ac_phase <= next_ac;
            o_frame <= next_frame;
        end
    end
    assign o_phase_1 = phase;
    assign o_phase_2 = ~phase & i_enable;
endmodule // lcs_timing_gen
`default_nettype wire

// File: src/lcs_common_driver.sv
/*
 Top of the common-row driver: master/slave pin direction, 20-bit scan
 register and level select per output. Assumes pins are resolved by the
 surroundings from the output enables.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_common_driver
    import lcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_master_mode,
    input wire logic i_shift_way_pick,
    input wire logic i_frequency_select,
    input wire logic i_duty_pick_1,
    input wire logic i_duty_pick_2,
    input wire logic i_duty_pick_3,
    input wire logic i_left_shift_port,
    output logic o_left_shift_port,
    output logic o_left_shift_port_oe,
    input wire logic i_right_shift_port,
    output logic o_right_shift_port,
    output logic o_right_shift_port_oe,
    input wire logic i_ac_phase,
    output logic o_ac_phase,
    output logic o_ac_phase_oe,
    input wire logic i_row_shift_strobe,
    output logic o_row_shift_strobe,
    output logic o_row_shift_strobe_oe,
    output logic o_frame_start_pulse,
    output logic o_phase_1,
    output logic o_phase_2,
    output logic [2*lcs_pkg::ROWS-1:0] o_common_outputs
);
    import lcs_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic mode_s;
    logic way_s;
    logic freq_s;
    logic [2:0] duty_s;
    logic left_s;
    logic right_s;
    logic ac_s;
    logic strobe_s;
    logic [9:0] raw_in;
    logic [9:0] syn_in;
    assign raw_in = {i_master_mode, i_shift_way_pick, i_frequency_select,
                     i_duty_pick_3, i_duty_pick_2, i_duty_pick_1,
                     i_left_shift_port, i_right_shift_port,
                     i_ac_phase, i_row_shift_strobe};
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_sync
            lcs_sync u_sync (
                .i_clock(i_clock),
                .i_reset_n(i_reset_n),
                .i_async(raw_in[gi]),
                .o_sync(syn_in[gi])
            );
        end
    endgenerate
    assign {mode_s, way_s, freq_s, duty_s, left_s, right_s, ac_s,
            strobe_s} = syn_in;

    // ==========================================================
    // Oscillator emulation and timing generator
    // ==========================================================
    logic [OSC_CNT_W-1:0] osc_cnt;
    logic [OSC_CNT_W-1:0] next_osc_cnt;
    logic osc_tick;
    logic next_osc_tick;
    logic [ROW_CNT_W-1:0] rows_sel;
    logic gen_p1;
    logic gen_p2;
    logic gen_strobe;
    logic gen_ac;
    logic gen_frame;

    // Frequency select kept for pin compatibility; the emulated
    // oscillator has a single rate.
    logic unused_freq;
    assign unused_freq = freq_s;

    always_comb begin
        next_osc_cnt = osc_cnt;
        next_osc_tick = 1'b0;
        // oscillator runs in master mode only
        if (mode_s) begin
            if (osc_cnt == OSC_CNT_W'(OSC_DIV - 1)) begin
                next_osc_cnt = '0;
                next_osc_tick = 1'b1;
            end else begin
                next_osc_cnt = osc_cnt + 1'b1;
            end
        end else begin
            next_osc_cnt = '0;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osc_cnt <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_cnt <= next_osc_cnt;
            osc_tick <= next_osc_tick;
        end
    end

    // duty only matters in master mode
    assign rows_sel = DUTY_TABLE[duty_s];

    // generator held idle in slave mode
    lcs_timing_gen u_gen (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_enable(mode_s),
        .i_osc_tick(osc_tick),
        .i_rows(rows_sel),
        .o_phase_1(gen_p1),
        .o_phase_2(gen_p2),
        .o_strobe(gen_strobe),
        .o_ac_phase(gen_ac),
        .o_frame(gen_frame)
    );

    // ==========================================================
    // Scan register
    // ==========================================================
    logic [ROWS-1:0] scan;
    logic [ROWS-1:0] next_scan;
    logic strobe_eff;
    logic strobe_prev;
    logic ac_eff;
    logic frame_d;
    logic shift_in;

    // slave takes strobe and phase from pins
    assign strobe_eff = mode_s ? gen_strobe : strobe_s;
    assign ac_eff = mode_s ? gen_ac : ac_s;

    always_comb begin
        // In master mode the token enters on the frame marker
        shift_in = mode_s ? gen_frame : (way_s ? right_s : left_s);
        next_scan = scan;
        if (strobe_eff && !strobe_prev) begin
            if (way_s) begin
                next_scan = {shift_in, scan[ROWS-1:1]};
            end else begin
                next_scan = {scan[ROWS-2:0], shift_in};
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scan <= '0;
            strobe_prev <= 1'b0;
            frame_d <= 1'b0;
        end else begin
            scan <= next_scan;
            strobe_prev <= strobe_eff;
            frame_d <= gen_frame;
        end
    end

    // ==========================================================
    // Level selection and pin drive
    // ==========================================================
    function automatic logic [1:0] pick_level(input logic bit_set,
                                              input logic ac);
        // set bit picks A or B by phase
        if (bit_set) begin
            pick_level = ac ? LVL_SEL_B : LVL_SEL_A;
        end else begin
            pick_level = ac ? LVL_NSEL_B : LVL_NSEL_A;
        end
    endfunction

    logic [2*ROWS-1:0] next_levels;
    always_comb begin
        next_levels = '0;
        for (int k = 0; k < ROWS; k++) begin
            next_levels[2*k +: 2] = pick_level(scan[k], ac_eff);
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_common_outputs <= {ROWS{LVL_NSEL_A}};
            o_left_shift_port <= 1'b0;
            o_right_shift_port <= 1'b0;
            o_left_shift_port_oe <= 1'b0;
            o_right_shift_port_oe <= 1'b0;
            o_ac_phase <= 1'b0;
            o_ac_phase_oe <= 1'b0;
            o_row_shift_strobe <= 1'b0;
            o_row_shift_strobe_oe <= 1'b0;
            o_frame_start_pulse <= 1'b0;
            o_phase_1 <= 1'b0;
            o_phase_2 <= 1'b0;
        end else begin
            o_common_outputs <= next_levels;
            // master drives shift ports, phase, strobe
            o_ac_phase_oe <= mode_s;
            o_row_shift_strobe_oe <= mode_s;
            o_ac_phase <= gen_ac;
            o_row_shift_strobe <= gen_strobe;
            // slave drives only the non-input port
            o_left_shift_port_oe <= mode_s | way_s;
            o_right_shift_port_oe <= mode_s | ~way_s;
            // Carry-out is the bit leaving the far end
            o_left_shift_port <= way_s ? scan[0] : frame_d;
            o_right_shift_port <= way_s ? frame_d : scan[ROWS-1];
            o_frame_start_pulse <= gen_frame;
            o_phase_1 <= gen_p1;
            o_phase_2 <= gen_p2;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_slave_no_drive;
        @(posedge i_clock) disable iff (!i_reset_n)
        !mode_s ##2 !mode_s |-> !o_ac_phase_oe && !o_row_shift_strobe_oe;
    endproperty
    a_slave_no_drive: assert property (p_slave_no_drive)
        else $error("slave drives phase or strobe");

    property p_master_drive;
        @(posedge i_clock) disable iff (!i_reset_n)
        mode_s |=> o_left_shift_port_oe && o_right_shift_port_oe
                   && o_ac_phase_oe;
    endproperty
    a_master_drive: assert property (p_master_drive)
        else $error("master not driving pins");

    property p_slave_gen_idle;
        @(posedge i_clock) disable iff (!i_reset_n)
        !mode_s ##1 !mode_s |=> !gen_strobe && !gen_frame;
    endproperty
    a_slave_gen_idle: assert property (p_slave_gen_idle)
        else $error("generator active in slave");

    property p_half_rate;
        @(posedge i_clock) disable iff (!i_reset_n)
        mode_s && osc_tick ##1 mode_s |-> gen_p1 != $past(gen_p1);
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("phase not toggling on tick");

    property p_no_tick_hold;
        @(posedge i_clock) disable iff (!i_reset_n)
        mode_s && !osc_tick ##1 mode_s |-> $stable(gen_p1);
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold)
        else $error("phase changed without tick");

    sequence s_rise;
        strobe_eff && !strobe_prev;
    endsequence
    property p_shift;
        @(posedge i_clock) disable iff (!i_reset_n)
        (s_rise and !way_s) |=> scan[ROWS-1:1] == $past(scan[ROWS-2:0]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("scan did not shift");

    property p_shift_right;
        @(posedge i_clock) disable iff (!i_reset_n)
        (s_rise and way_s) |=> scan[ROWS-2:0] == $past(scan[ROWS-1:1]);
    endproperty
    a_shift_right: assert property (p_shift_right)
        else $error("scan did not shift toward bit zero");

    property p_hold;
        @(posedge i_clock) disable iff (!i_reset_n)
        !(strobe_eff && !strobe_prev) |=> $stable(scan);
    endproperty
    a_hold: assert property (p_hold)
        else $error("scan moved without strobe");

    property p_level;
        @(posedge i_clock) disable iff (!i_reset_n)
        1 |=> o_common_outputs[1] == !$past(scan[0]) &&
              o_common_outputs[0] == $past(ac_eff);
    endproperty
    a_level: assert property (p_level)
        else $error("level select wrong");
endmodule // lcs_common_driver
`default_nettype wire

// File: dv/lcs_far_model.sv
/*
 Far-side model: the timing master that feeds a slave common driver
 with its strobe, AC phase and scan token. Assumes the bench resolves
 each pin from the enables and calls the tasks from its own thread.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_far_model (
    input wire logic i_clock,
    output logic o_data,
    output logic o_strobe,
    output logic o_ac_phase
);
    // ==============================================================
    // Idle levels
    // ==============================================================
    initial begin
        o_data = 1'b0;
        o_strobe = 1'b0;
        o_ac_phase = 1'b0;
    end

    // ==============================================================
    // One row shift
    // ==============================================================
    // routed token shift
    // Data stays put across the rise, then is inverted once its hold
    // time is over so a design that samples late sees garbage.
    task automatic shift_in(input logic bit_in);
        @(posedge i_clock);
        o_data <= bit_in;
        repeat (4) @(posedge i_clock);
        o_strobe <= 1'b1;
        repeat (4) @(posedge i_clock);
        o_strobe <= 1'b0;
        repeat (4) @(posedge i_clock);
        o_data <= ~bit_in;
    endtask

    task automatic set_ac(input logic value);
        @(posedge i_clock);
        o_ac_phase <= value;
    endtask
endmodule // lcs_far_model
`default_nettype wire

// File: dv/tb.sv
/*
 Self-checking bench for the common-row driver: slave scan, AC phase,
 pin directions and master clock division. Assumes the far-side model
 supplies slave timing and that the bench resolves the shared pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lcs_pkg::*;
    logic i_clock, i_reset_n, i_master_mode, i_shift_way_pick;
    logic i_frequency_select, i_duty_pick_1, i_duty_pick_2, i_duty_pick_3;
    logic left_w, right_w, ac_w, strobe_w, p_data, p_strobe, p_ac, drv;
    logic o_left_shift_port, o_left_shift_port_oe;
    logic o_right_shift_port, o_right_shift_port_oe;
    logic o_ac_phase, o_ac_phase_oe, o_row_shift_strobe;
    logic o_row_shift_strobe_oe, o_frame_start_pulse, o_phase_1, o_phase_2;
    logic [2*ROWS-1:0] o_common_outputs;
    logic [ROWS-1:0] exp_scan;
    logic exp_ac;
    int bad_count, n_checks, cycles;

    // ==============================================================
    // Pin resolution; a released line shows the inverse value
    // ==============================================================
    assign drv = ~i_master_mode;
    assign left_w = o_left_shift_port_oe ? o_left_shift_port :
        ((drv && !i_shift_way_pick) ? p_data : ~o_left_shift_port);
    assign right_w = o_right_shift_port_oe ? o_right_shift_port :
        ((drv && i_shift_way_pick) ? p_data : ~o_right_shift_port);
    assign ac_w = o_ac_phase_oe ? o_ac_phase : (drv ? p_ac : ~o_ac_phase);
    assign strobe_w = o_row_shift_strobe_oe ? o_row_shift_strobe :
        (drv ? p_strobe : ~o_row_shift_strobe);

    lcs_far_model lcs_far_model_inst (
        .i_clock(i_clock),
        .o_data(p_data),
        .o_strobe(p_strobe),
        .o_ac_phase(p_ac)
    );

    lcs_common_driver lcs_common_driver_inst (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_master_mode(i_master_mode),
        .i_shift_way_pick(i_shift_way_pick),
        .i_frequency_select(i_frequency_select),
        .i_duty_pick_1(i_duty_pick_1),
        .i_duty_pick_2(i_duty_pick_2),
        .i_duty_pick_3(i_duty_pick_3),
        .i_left_shift_port(left_w),
        .o_left_shift_port(o_left_shift_port),
        .o_left_shift_port_oe(o_left_shift_port_oe),
        .i_right_shift_port(right_w),
        .o_right_shift_port(o_right_shift_port),
        .o_right_shift_port_oe(o_right_shift_port_oe),
        .i_ac_phase(ac_w),
        .o_ac_phase(o_ac_phase),
        .o_ac_phase_oe(o_ac_phase_oe),
        .i_row_shift_strobe(strobe_w),
        .o_row_shift_strobe(o_row_shift_strobe),
        .o_row_shift_strobe_oe(o_row_shift_strobe_oe),
        .o_frame_start_pulse(o_frame_start_pulse),
        .o_phase_1(o_phase_1),
        .o_phase_2(o_phase_2),
        .o_common_outputs(o_common_outputs)
    );

    // ==============================================================
    // Helpers
    // ==============================================================
    task automatic check(input string what, input logic [39:0] exp,
                         input logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [39:0] exp_commons();
        logic [39:0] v;
        for (int k = 0; k < ROWS; k++)
            v[2*k +: 2] = {~exp_scan[k], exp_ac};
        return v;
    endfunction

    function automatic logic [3:0] oes();
        return {o_ac_phase_oe, o_row_shift_strobe_oe,
                o_left_shift_port_oe, o_right_shift_port_oe};
    endfunction

    // Samples on the falling edge so registered outputs have settled
    task automatic wait_level(input logic strobe_sel, input logic lvl,
                              output int n);
        n = 0;
        while ((strobe_sel ? o_row_shift_strobe : o_phase_1) !== lvl
               && n < 40000) begin
            @(negedge i_clock);
            n++;
        end
    endtask

    task print_verdict();
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==============================================================
    // Scenarios
    // ==============================================================
    task automatic t_reset_state();
        @(negedge i_clock);
        check("commons", exp_commons(), o_common_outputs);
        check("phases", 40'h0, {o_phase_1, o_phase_2});
    endtask

    task automatic t_scan(input logic way);
        logic b;
        @(posedge i_clock);
        i_shift_way_pick <= way;
        repeat (4) @(negedge i_clock);
        check("oe", way ? 4'h2 : 4'h1, oes());
        for (int k = 0; k < ROWS; k++) begin
            b = (k == 0);
            lcs_far_model_inst.shift_in(b);
            exp_scan = way ? {b, exp_scan[19:1]} : {exp_scan[18:0], b};
            @(negedge i_clock);
            check("commons", exp_commons(), o_common_outputs);
        end
        check("carry", 40'(way ? exp_scan[0] : exp_scan[19]),
              40'(way ? o_left_shift_port : o_right_shift_port));
        for (int k = 1; k >= 0; k--) begin
            lcs_far_model_inst.set_ac(k[0]);
            exp_ac = k[0];
            repeat (8) @(negedge i_clock);
            check("ac_levels", exp_commons(), o_common_outputs);
        end
    endtask

    // Duty and frequency picks must not wake anything in slave mode
    task automatic t_slave_ignores();
        @(posedge i_clock);
        {i_duty_pick_3, i_duty_pick_2, i_duty_pick_1} <= 3'h4;
        i_frequency_select <= 1'b1;
        repeat (12) @(negedge i_clock);
        check("commons", exp_commons(), o_common_outputs);
        check("phases", 40'h0, {o_phase_1, o_phase_2});
        check("frame", 40'h0, 40'(o_frame_start_pulse));
    endtask

    task automatic t_master();
        int n;
        @(posedge i_clock);
        i_master_mode <= 1'b1;
        // low duty, one device as master
        {i_duty_pick_3, i_duty_pick_2, i_duty_pick_1} <= 3'h0;
        repeat (8) @(negedge i_clock);
        check("oe", 4'hF, oes());
        wait_level(1'b0, 1'b0, n);
        wait_level(1'b0, 1'b1, n);
        wait_level(1'b0, 1'b0, n);
        check("phase_half", 40'(OSC_DIV), 40'(n));
        check("phase_pair", 40'({~o_phase_1}), 40'(o_phase_2));
        wait_level(1'b1, 1'b0, n);
        wait_level(1'b1, 1'b1, n);
        wait_level(1'b1, 1'b0, n);
        check("strobe_high", 40'((ROW_TICKS / 2) * OSC_DIV), 40'(n));
        wait_level(1'b1, 1'b1, n);
        check("strobe_low", 40'((ROW_TICKS / 2) * OSC_DIV), 40'(n));
        // Too few rows have passed for a frame, so no marker and no flip
        @(negedge i_clock);
        check("frame", 40'h0, 40'(o_frame_start_pulse));
        check("ac_master", 40'h0, 40'(o_ac_phase));
        // Strobe rises with the marker low have shifted the token out
        exp_scan = '0;
        check("commons", exp_commons(), o_common_outputs);
    endtask

    // ==============================================================
    // Clock, watchdog and main sequence
    // ==============================================================
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 100000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        exp_scan = '0;
        exp_ac = 1'b0;
        i_reset_n = 1'b0;
        i_master_mode = 1'b0;
        i_shift_way_pick = 1'b0;
        i_frequency_select = 1'b0;
        i_duty_pick_1 = 1'b0;
        i_duty_pick_2 = 1'b0;
        i_duty_pick_3 = 1'b0;
        repeat (3) @(posedge i_clock);
        i_reset_n <= 1'b1;
        t_reset_state();
        t_scan(1'b0);
        t_scan(1'b1);
        t_slave_ignores();
        t_master();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
